// ### rtl/tmr_pkg.sv
// Package for the timer0 block with its shared prescaler.
// Assumes one 100 MHz clock, one oscillator period per clock cycle.
package tmr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] TMR_OFS_COUNT  = 8'h01;
    localparam logic [7:0] TMR_OFS_INTCTL = 8'h0b;
    localparam logic [7:0] TMR_OFS_OPTION = 8'h81;
    localparam logic [7:0] TMR_OFS_DIR    = 8'h85;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] TMR_RST_COUNT  = 8'h00;
    localparam logic [7:0] TMR_RST_INTCTL = 8'h00;
    localparam logic [7:0] TMR_RST_OPTION = 8'hff;
    localparam logic [5:0] TMR_RST_DIR    = 6'h3f;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TMR_BIT_CLK_SRC    = 5;
    localparam int TMR_BIT_EDGE       = 4;
    localparam int TMR_BIT_ASSIGN     = 3;
    localparam int TMR_BIT_RATIO_LO   = 0;
    localparam int TMR_BIT_OVF_EN     = 5;
    localparam int TMR_BIT_OVF_FLAG   = 2;
    localparam int TMR_BIT_DIR_INONLY = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int TMR_CLK_PERIOD_NS = 10;
    localparam int TMR_TOSC_NS       = 10;
    localparam int TMR_TOSC_CYCLES   = (TMR_TOSC_NS + TMR_CLK_PERIOD_NS - 1) / TMR_CLK_PERIOD_NS;
    localparam int TMR_Q_PHASES      = 4;
    localparam logic [1:0] TMR_WR_INHIBIT = 2'h2;
    localparam logic [1:0] TMR_PH_Q2      = 2'h1;
    localparam logic [1:0] TMR_PH_Q4      = 2'h3;

    // ------------------------------------------------------------
    // Register bus request
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tmr_bus_req_t;

endpackage : tmr_pkg

// ### rtl/tmr_timer0.sv
// Timer0 block: 8-bit timer/counter with a prescaler shared with the watchdog.
// Assumes a plain register port, a watchdog core outside giving timeout ticks,
// and a CPU outside that signals sleep and the watchdog clear instruction.
//
// Decided for this implementation: the address-and-strobe port.
module tmr_timer0 (
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire tmr_pkg::tmr_bus_req_t bus_i,
    output logic [7:0]                rdata_o,
    input  wire logic                 counter_input_pin_i,
    input  wire logic                 sleep_i,
    input  wire logic                 watchdog_tick_i,
    input  wire logic                 watchdog_clear_instr_i,
    output logic                      watchdog_timeout_o,
    output logic                      overflow_irq_o,
    output logic [5:0]                port_direction_o
);
    import tmr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [1:0] phase;
    logic [7:0] timer0_count;
    logic [7:0] option_config;
    logic       overflow_flag;
    logic       overflow_irq_enable;
    logic [7:0] intctl_other;
    logic [5:0] port_direction;
    logic [7:0] prescaler;
    logic [1:0] inhibit;
    logic       pin_s1;
    logic       pin_s2;
    logic       pin_s3;
    logic       pin_filt;
    logic       lvl_prev;
    logic       sampled;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire        sel_count  = bus_i.addr == TMR_OFS_COUNT;
    wire        sel_intctl = bus_i.addr == TMR_OFS_INTCTL;
    wire        sel_option = bus_i.addr == TMR_OFS_OPTION;
    wire        sel_dir    = bus_i.addr == TMR_OFS_DIR;
    wire        wr_count   = bus_i.wr & sel_count;
    wire        wr_intctl  = bus_i.wr & sel_intctl;
    wire        wr_option  = bus_i.wr & sel_option;
    wire        wr_dir     = bus_i.wr & sel_dir;

    wire        clock_source_select = option_config[TMR_BIT_CLK_SRC];
    wire        edge_select         = option_config[TMR_BIT_EDGE];
    wire        prescaler_assign    = option_config[TMR_BIT_ASSIGN];
    wire [2:0]  prescale_ratio      = option_config[TMR_BIT_RATIO_LO +: 3];

    wire        q2_en = phase == TMR_PH_Q2;
    wire        q4_en = phase == TMR_PH_Q4;

    // ------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------
    wire        pin_agree = pin_s2 == pin_s3;
    wire        next_filt = pin_agree ? pin_s3 : pin_filt;
    wire        lvl       = pin_filt ^ edge_select;
    wire        pin_edge  = lvl & ~lvl_prev;
    wire        src_ev    = clock_source_select ? pin_edge : q4_en;
    wire        run       = ~sleep_i;

    wire        pre_to_tmr = ~prescaler_assign;
    wire        pre_ev     = prescaler_assign ? watchdog_tick_i
                                              : (src_ev & run);
    wire [7:0]  pre_inc    = prescaler + 8'h01;
    wire        pre_clr    = (wr_count & pre_to_tmr)
                           | (watchdog_clear_instr_i & prescaler_assign);
    wire        pre_out    = prescaler[prescale_ratio];

    wire [7:0]  wdt_mask   = ~(8'hff << prescale_ratio);
    wire        wdt_hit    = prescaler_assign & watchdog_tick_i
                           & ((prescaler & wdt_mask) == wdt_mask);

    // Sampling stage for prescaler output, or for the filtered, edge-adjusted input level
    wire        samp_in    = pre_to_tmr ? pre_out : lvl;
    wire        samp_en    = q2_en | q4_en;
    wire        samp_rise  = samp_en & samp_in & ~sampled;
    wire        direct     = prescaler_assign & ~clock_source_select;
    wire        tmr_ev     = direct ? q4_en : samp_rise;
    wire        tmr_inc    = tmr_ev & run & (inhibit == 2'h0)
                           & (pre_to_tmr | ~clock_source_select
                              | prescaler_assign);
    wire        wrap       = tmr_inc & (timer0_count == 8'hff);
    wire [7:0]  next_count = wr_count ? bus_i.wdata
                           : (tmr_inc ? timer0_count + 8'h01 : timer0_count);

    // Overflow flag: hardware set wins over a software clear
    wire        next_flag  = wrap
                           | (wr_intctl ? bus_i.wdata[TMR_BIT_OVF_FLAG]
                                        : overflow_flag);
    wire        next_en    = wr_intctl ? bus_i.wdata[TMR_BIT_OVF_EN]
                                       : overflow_irq_enable;
    wire [1:0]  next_inhibit = wr_count ? TMR_WR_INHIBIT
                             : ((q4_en && inhibit != 2'h0) ? inhibit - 2'h1
                                                          : inhibit);

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire [7:0]  intctl_rd  = {intctl_other[7:6], overflow_irq_enable,
                              intctl_other[4:3], overflow_flag,
                              intctl_other[1:0]};
    wire [7:0]  dir_rd     = {2'b00, port_direction[5:4], 1'b1,
                              port_direction[2:0]};
    wire [7:0]  next_rdata = sel_count  ? timer0_count
                           : sel_intctl ? intctl_rd
                           : sel_option ? option_config
                           : sel_dir    ? dir_rd
                           : 8'h00;

    // ------------------------------------------------------------
    // Phase clock: Q1 to Q4 of each instruction cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Input synchroniser, first stage
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1 <= 1'b0;
        end else begin
            pin_s1 <= counter_input_pin_i;
        end
    end

    // ------------------------------------------------------------
    // Input synchroniser, second stage
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s2 <= 1'b0;
        end else begin
            pin_s2 <= pin_s1;
        end
    end

    // ------------------------------------------------------------
    // Input synchroniser, third stage
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s3 <= 1'b0;
        end else begin
            pin_s3 <= pin_s2;
        end
    end

    // ------------------------------------------------------------
    // Accepted input level
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_filt <= 1'b0;
        end else begin
            pin_filt <= next_filt;
        end
    end

    // ------------------------------------------------------------
    // Edge detector of the counting level
    // ------------------------------------------------------------
    // Starts at the idle level of the reset setup, so no false edge follows reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvl_prev <= TMR_RST_OPTION[TMR_BIT_EDGE];
        end else begin
            lvl_prev <= lvl;
        end
    end

    // ------------------------------------------------------------
    // Q2 and Q4 sampling stage
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sampled <= TMR_RST_OPTION[TMR_BIT_EDGE];
        end else if (samp_en) begin
            sampled <= samp_in;
        end
    end

    // ------------------------------------------------------------
    // Shared prescaler
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prescaler <= 8'h00;
        end else if (pre_clr) begin
            prescaler <= 8'h00;
        end else if (pre_ev) begin
            prescaler <= pre_inc;
        end
    end

    // ------------------------------------------------------------
    // Watchdog postscaler output
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            watchdog_timeout_o <= 1'b0;
        end else begin
            watchdog_timeout_o <= wdt_hit;
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer0_count <= TMR_RST_COUNT;
        end else begin
            timer0_count <= next_count;
        end
    end

    // ------------------------------------------------------------
    // Increment inhibit after a counter write
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            inhibit <= 2'h0;
        end else begin
            inhibit <= next_inhibit;
        end
    end

    // ------------------------------------------------------------
    // Overflow flag
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overflow_flag <= TMR_RST_INTCTL[TMR_BIT_OVF_FLAG];
        end else begin
            overflow_flag <= next_flag;
        end
    end

    // ------------------------------------------------------------
    // Overflow interrupt enable
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overflow_irq_enable <= TMR_RST_INTCTL[TMR_BIT_OVF_EN];
        end else begin
            overflow_irq_enable <= next_en;
        end
    end

    // ------------------------------------------------------------
    // Overflow interrupt request
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overflow_irq_o <= 1'b0;
        end else begin
            overflow_irq_o <= next_flag & next_en;
        end
    end

    // ------------------------------------------------------------
    // Other interrupt-control bits
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            intctl_other <= TMR_RST_INTCTL;
        end else if (wr_intctl) begin
            intctl_other <= bus_i.wdata;
        end
    end

    // ------------------------------------------------------------
    // Option register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            option_config <= TMR_RST_OPTION;
        end else if (wr_option) begin
            option_config <= bus_i.wdata;
        end
    end

    // ------------------------------------------------------------
    // Port direction register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_direction <= TMR_RST_DIR;
        end else if (wr_dir) begin
            port_direction <= bus_i.wdata[5:0] | (6'h01 << TMR_BIT_DIR_INONLY);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Zero outside the read slot, so the data lines idle low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (bus_i.rd) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    assign port_direction_o = port_direction;

endmodule : tmr_timer0

// ### bench/tmr_timer0_properties.sv
// Checker of the timer0 block, sees its ports only.
// Assumes one clock and the async active-low reset.
module tmr_timer0_props (
    input wire logic                  clk_i,
    input wire logic                  rst_n_i,
    input wire tmr_pkg::tmr_bus_req_t bus_i,
    input wire logic [7:0]            rdata_o,
    input wire logic                  counter_input_pin_i,
    input wire logic                  sleep_i,
    input wire logic                  watchdog_tick_i,
    input wire logic                  watchdog_clear_instr_i,
    input wire logic                  watchdog_timeout_o,
    input wire logic                  overflow_irq_o,
    input wire logic [5:0]            port_direction_o
);
    import tmr_pkg::*;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    wire logic mapped = bus_i.addr inside {TMR_OFS_COUNT, TMR_OFS_INTCTL, TMR_OFS_OPTION, TMR_OFS_DIR};
    wire logic rd_dir = bus_i.rd && bus_i.addr == TMR_OFS_DIR;
    wire logic wr_dir = bus_i.wr && bus_i.addr == TMR_OFS_DIR;
    wire logic rd_ctl = bus_i.rd && bus_i.addr == TMR_OFS_INTCTL;
    wire logic wr_ctl = bus_i.wr && bus_i.addr == TMR_OFS_INTCTL;
    wire logic rd_irq = rdata_o[5] & rdata_o[2];
    a_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
        else $error("read data outside read slot");
    a_read_unmapped: assert property (bus_i.rd && !mapped |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_dir_fixed: assert property (port_direction_o[TMR_BIT_DIR_INONLY])
        else $error("input-only direction bit low");
    a_dir_write: assert property (wr_dir |=> port_direction_o == ($past(bus_i.wdata[5:0]) | 6'h08))
        else $error("direction write lost");
    a_dir_read: assert property (rd_dir |=> rdata_o == {2'h0, $past(port_direction_o)})
        else $error("direction read wrong");
    a_wd_after_tick: assert property (watchdog_timeout_o |-> $past(watchdog_tick_i))
        else $error("timeout without tick");
    a_irq_mask: assert property (wr_ctl && !bus_i.wdata[5] |=> !overflow_irq_o)
        else $error("request not masked");
    a_irq_match: assert property (rd_ctl |=> $past(overflow_irq_o) == rd_irq)
        else $error("request differs from flag and enable");
    c_irq: cover property (overflow_irq_o);
    c_wd: cover property (watchdog_timeout_o);
    c_pin: cover property ($rose(counter_input_pin_i));
endmodule : tmr_timer0_props

// ### bench/tmr_pulse_src.sv
// External pulse source on the counter input pin.
// Assumes the caller's process runs its tasks.
module tmr_pulse_src (
    input  wire logic clk_i,
    output logic      pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin_o = 1'b0;
    // Ends high: n rising and n-1 falling edges
    task automatic pulses(input int n);
        repeat (n) begin
            pin_o <= 1'b0;
            repeat ($urandom_range(8, 4)) @(posedge clk_i);
            pin_o <= 1'b1;
            repeat ($urandom_range(8, 4)) @(posedge clk_i);
        end
    endtask : pulses
    task automatic idle();
        pin_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask : idle
endmodule : tmr_pulse_src

// ### bench/test_tmr_timer0.sv
// Self-checking bench of the timer0 block.
// Assumes the pulse source model and the checker beside it.
module test_tmr_timer0;
    timeunit 1ns;
    timeprecision 1ns;
    import tmr_pkg::*;
    logic         clk_i = 0, rst_n_i = 0, sleep_i = 0, tick = 0, wclr = 0, wd_to, irq;
    tmr_bus_req_t bus_i = '0;
    logic [7:0]   rdata_o, v;
    logic [5:0]   dir;
    wire logic    pin;
    int           error_cnt = 0, check_count = 0, wd_cnt = 0, n;
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (wd_to === 1'b1) wd_cnt++;
    tmr_timer0 i_tmr_timer0 (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .counter_input_pin_i(pin), .sleep_i(sleep_i), .watchdog_tick_i(tick),
        .watchdog_clear_instr_i(wclr), .watchdog_timeout_o(wd_to), .overflow_irq_o(irq),
        .port_direction_o(dir));
    tmr_pulse_src i_tmr_pulse_src (.clk_i(clk_i), .pin_o(pin));
    task summarize();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) bus_i <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i) bus_i.wr <= 1'b0;
    endtask : wr
    task chk(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi, input string w);
        @(posedge clk_i) bus_i <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_i) bus_i.rd <= 1'b0;
        #1 v = rdata_o;
        check({7'h00, v >= lo && v <= hi}, 8'h01, w);
    endtask : chk
    task pulse_wd(input int ticks, input logic clr);
        @(posedge clk_i) wclr <= clr;
        @(posedge clk_i) wclr <= 1'b0;
        repeat (ticks) begin
            @(posedge clk_i) tick <= 1'b1;
            @(posedge clk_i) tick <= 1'b0;
            repeat (2) @(posedge clk_i);
        end
    endtask : pulse_wd
    // Clocks that cover eight counter increments at a ratio field
    function automatic int span(input int r);
        return 32 << (r + 1);
    endfunction : span
    initial begin
        #400us;
        error_cnt++;
        summarize();
    end
    initial begin
        void'($urandom(32'h958af1e7));
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        chk(TMR_OFS_OPTION, 8'hff, 8'hff, "option reset");
        chk(TMR_OFS_DIR, 8'h3f, 8'h3f, "direction reset");
        chk(8'h40, 8'h00, 8'h00, "unmapped");
        wr(TMR_OFS_DIR, 8'hc0);
        chk(TMR_OFS_DIR, 8'h08, 8'h08, "direction");
        wr(TMR_OFS_OPTION, 8'h08);
        n = $urandom_range(200, 0);
        wr(TMR_OFS_COUNT, n[7:0]);
        repeat (38) @(posedge clk_i);
        chk(TMR_OFS_COUNT, n[7:0] + 8'd7, n[7:0] + 8'd8, "timer");
        for (int r = 0; r < 8; r++) begin
            wr(TMR_OFS_OPTION, r[7:0]);
            wr(TMR_OFS_COUNT, 8'h00);
            repeat (span(r)) @(posedge clk_i);
            chk(TMR_OFS_COUNT, 8'd6, 8'd8, "ratio");
        end
        wr(TMR_OFS_INTCTL, 8'h20);
        wr(TMR_OFS_OPTION, 8'h08);
        wr(TMR_OFS_COUNT, 8'hfe);
        repeat (20) @(posedge clk_i);
        chk(TMR_OFS_INTCTL, 8'h24, 8'h24, "flag");
        check({7'h00, irq}, 8'h01, "request");
        wr(TMR_OFS_INTCTL, 8'h00);
        wr(TMR_OFS_COUNT, 8'hfe);
        repeat (60) @(posedge clk_i);
        chk(TMR_OFS_INTCTL, 8'h04, 8'h04, "masked flag");
        check({7'h00, irq}, 8'h00, "masked request");
        @(posedge clk_i) sleep_i <= 1'b1;
        wr(TMR_OFS_COUNT, 8'h10);
        repeat (40) @(posedge clk_i);
        chk(TMR_OFS_COUNT, 8'h10, 8'h10, "sleep");
        @(posedge clk_i) sleep_i <= 1'b0;
        for (int e = 0; e < 2; e++) begin
            wr(TMR_OFS_OPTION, 8'h28 | 8'(e << 4));
            wr(TMR_OFS_COUNT, 8'h00);
            n = $urandom_range(9, 3);
            i_tmr_pulse_src.pulses(n);
            repeat (8) @(posedge clk_i);
            chk(TMR_OFS_COUNT, 8'(n - e), 8'(n - e), "edges");
            i_tmr_pulse_src.idle();
        end
        wr(TMR_OFS_OPTION, 8'h22);
        i_tmr_pulse_src.pulses(4);
        i_tmr_pulse_src.idle();
        wr(TMR_OFS_COUNT, 8'h00);
        i_tmr_pulse_src.pulses(5);
        repeat (8) @(posedge clk_i);
        chk(TMR_OFS_COUNT, 8'h01, 8'h01, "divided edges");
        wr(TMR_OFS_COUNT, 8'h00);
        pulse_wd(0, 1'b1);
        wr(TMR_OFS_OPTION, 8'h0a);
        pulse_wd(3, 1'b1);
        pulse_wd(3, 1'b1);
        check(wd_cnt[7:0], 8'h00, "postscale cleared");
        pulse_wd(1, 1'b0);
        check(wd_cnt[7:0], 8'h01, "postscale");
        summarize();
    end
endmodule : test_tmr_timer0
bind tmr_timer0 tmr_timer0_props i_tmr_timer0_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .counter_input_pin_i(counter_input_pin_i),
    .sleep_i(sleep_i), .watchdog_tick_i(watchdog_tick_i),
    .watchdog_clear_instr_i(watchdog_clear_instr_i), .watchdog_timeout_o(watchdog_timeout_o),
    .overflow_irq_o(overflow_irq_o), .port_direction_o(port_direction_o));
